// ===== design/omos_pkg.sv
`default_nettype none

package omos_pkg;

    // Timing.
    localparam int CLK_HZ             = 250_000_000;
    localparam int REF_SLOW_HZ        = 32768;
    localparam int SLOW_TICK_CYCLES   = CLK_HZ / REF_SLOW_HZ;
    localparam int ACTIVE_HOLD_NS     = 4000;
    localparam int ACTIVE_HOLD_CYCLES = (ACTIVE_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int HOLD_W             = $clog2(ACTIVE_HOLD_CYCLES + 1);

    // Register map, byte addresses on a 32-bit Avalon-MM slave.
    localparam int         ADDR_W     = 4;
    localparam int         DATA_W     = 32;
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_CMD    = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_WAKE   = 4'hC;

    // Field positions.
    localparam int CTRL_PSV_LSB    = 0;
    localparam int CTRL_FLOW_BIT   = 2;
    localparam int CTRL_NETREG_BIT = 3;
    localparam int CMD_SHUT_BIT    = 0;
    localparam int CMD_CSTART_BIT  = 1;
    localparam int CMD_CEND_BIT    = 2;
    localparam int ST_MODE_LSB     = 0;
    localparam int ST_RAW_LSB      = 3;
    localparam int ST_PREV_BIT     = 6;
    localparam int ST_CHG_BIT      = 7;
    localparam int ST_SUP_BIT      = 8;
    localparam int ST_NETREG_BIT   = 9;
    localparam int WAKE_REG_LSB    = 0;
    localparam int WAKE_UNREG_LSB  = 16;

    // Reset values and setting codes.
    localparam logic [1:0]  PSV_OFF          = 2'h0;
    localparam logic [1:0]  PSV_RESET        = 2'h1;
    localparam logic [1:0]  PSV_RTS          = 2'h2;
    localparam logic        FLOW_RESET       = 1'h1;
    localparam logic [15:0] WAKE_REG_RESET   = 16'h0800;
    localparam logic [15:0] WAKE_UNREG_RESET = 16'h4000;

    // Pin bundle positions and their idle levels.
    localparam int         PIN_COUNT    = 6;
    localparam int         PIN_SUPPLY   = 0;
    localparam int         PIN_CHARGER  = 1;
    localparam int         PIN_SWITCH   = 2;
    localparam int         PIN_ALARM    = 3;
    localparam int         PIN_RTS      = 4;
    localparam int         PIN_TXD      = 5;
    localparam logic [5:0] PIN_IDLE_LVL = 6'h34;

    typedef enum logic [2:0] {
        OMOS_NOPWR  = 3'h0,
        OMOS_OFF    = 3'h1,
        OMOS_IDLE   = 3'h2,
        OMOS_ACTIVE = 3'h3,
        OMOS_CONN   = 3'h4,
        OMOS_PRECHG = 3'h5,
        OMOS_CHARGE = 3'h6
    } omos_state_t;

    typedef struct packed {
        logic [1:0]  psv;
        logic        flow_en;
        logic        net_reg;
        logic [15:0] wake_reg;
        logic [15:0] wake_unreg;
    } omos_cfg_t;

    typedef struct packed {
        logic cts_n;
        logic ref_fast;
        logic if_en;
        logic precharge;
        logic charge_ctrl;
        logic rtc_run;
    } omos_pins_t;

endpackage

`default_nettype wire

// ===== design/omos_pin_sync.sv
`default_nettype none

module omos_pin_sync #(
    parameter int             W        = 1,
    parameter logic [W-1:0]   IDLE_LVL = '0
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         resetn,
    // Asynchronous pins.
    input  wire logic [W-1:0] pin_in,
    // Synchronised level and edges.
    output logic      [W-1:0] lvl,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } omos_sync_st_t;

    omos_sync_st_t st_ff;
    omos_sync_st_t nxt_st;

    // Resetting to the idle level keeps release of reset from faking an edge.
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = pin_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff <= '{s1: IDLE_LVL, s2: IDLE_LVL, s3: IDLE_LVL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign lvl  = st_ff.s2;
    assign rise = st_ff.s2 & ~st_ff.s3;
    assign fall = ~st_ff.s2 & st_ff.s3;

endmodule // omos_pin_sync

`default_nettype wire

// ===== design/omos_tick_div.sv
`default_nettype none

module omos_tick_div #(
    parameter int DIV = 2
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic resetn,
    // One-cycle enable every DIV cycles.
    output logic      tick
);

    localparam int CW = $clog2(DIV + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } omos_div_st_t;

    omos_div_st_t st_ff;
    omos_div_st_t nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt == CW'(DIV - 1)) begin
            nxt_st.cnt  = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

endmodule // omos_tick_div

`default_nettype wire

// ===== design/omos_sequencer.sv
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`default_nettype none

// Operation
// - In power-off with good supply, a falling switch-on edge switches the device on.
// - In power-off, an alarm or charger rising edge also switches on.
// - Not powered, every switch-on source is ignored.
// - Shutdown command enters power-off; only the clock timer runs, interfaces off.
// - Idle is entered automatically by default unless the host disables it.
// - Registered idle device wakes periodically to active at network-set times.
// - Unregistered idle device still wakes periodically to check external activity.
// - A clock alarm in idle wakes the device to active.
// - Serial data in idle wakes to active when hardware flow control is on.
// - Request-to-send ON wakes idle only when the power-saving setting is 2.
// - Clear-to-send is OFF while idle and not accepting data.
// - Slow reference while idle, fast reference while active or connected.
// - Idle disables the interfaces and refuses data; active enables them.
// - Connected during a call, interfaces enabled, no power saving.
// - Call end returns to the idle or active state held before the call.
// - Low battery with charger: stay off and force slow pre-charge.
// - Good battery with charger: processor-governed charging while switched on.
module omos_sequencer #(
    parameter int TICK_DIV  = omos_pkg::SLOW_TICK_CYCLES,
    parameter int HOLD_CYC  = omos_pkg::ACTIVE_HOLD_CYCLES
) (
    // Clock and reset.
    input  wire logic                        clk,
    input  wire logic                        resetn,
    // Avalon-MM slave.
    input  wire logic [omos_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [omos_pkg::DATA_W-1:0] avs_writedata,
    output logic      [omos_pkg::DATA_W-1:0] avs_readdata,
    output logic                             avs_waitrequest,
    // Pins from outside the clock domain.
    input  wire logic                        supply_ok,
    input  wire logic                        charger_detect,
    input  wire logic                        switch_on_input_n,
    input  wire logic                        rtc_alarm,
    input  wire logic                        rts_n,
    input  wire logic                        host_txd,
    // Mode outputs.
    output omos_pkg::omos_pins_t             mode_pins
);

    typedef struct packed {
        omos_pkg::omos_state_t                  state;
        logic                                   prev_idle;
        omos_pkg::omos_cfg_t                    cfg;
        logic [omos_pkg::HOLD_W-1:0]            hold_cnt;
        logic [15:0]                            wake_cnt;
        omos_pkg::omos_pins_t                   pins;
        logic                                   waitreq;
        logic [omos_pkg::DATA_W-1:0]            rdata;
    } omos_core_st_t;

    omos_core_st_t st_ff;
    omos_core_st_t nxt_st;

    logic [omos_pkg::PIN_COUNT-1:0] pin_lvl;
    logic [omos_pkg::PIN_COUNT-1:0] pin_rise;
    logic [omos_pkg::PIN_COUNT-1:0] pin_fall;
    logic                           tick;

    omos_pin_sync #(
        .W        (omos_pkg::PIN_COUNT),
        .IDLE_LVL (omos_pkg::PIN_IDLE_LVL)
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .pin_in ({host_txd, rts_n, rtc_alarm, switch_on_input_n, charger_detect, supply_ok}),
        .lvl    (pin_lvl),
        .rise   (pin_rise),
        .fall   (pin_fall)
    );

    omos_tick_div #(
        .DIV (TICK_DIV)
    ) u_tick (
        .clk    (clk),
        .resetn (resetn),
        .tick   (tick)
    );

    logic sup;
    logic chg;
    logic sw_f;
    logic al_r;
    logic chg_r;
    logic rts_f;
    logic txd_f;
    logic wr_done;
    logic cmd_wr;
    logic cmd_shut;
    logic cmd_cs;
    logic cmd_ce;

    assign sup      = pin_lvl[omos_pkg::PIN_SUPPLY];
    assign chg      = pin_lvl[omos_pkg::PIN_CHARGER];
    assign sw_f     = pin_fall[omos_pkg::PIN_SWITCH];
    assign al_r     = pin_rise[omos_pkg::PIN_ALARM];
    assign chg_r    = pin_rise[omos_pkg::PIN_CHARGER];
    assign rts_f    = pin_fall[omos_pkg::PIN_RTS];
    assign txd_f    = pin_fall[omos_pkg::PIN_TXD];
    // A write takes effect only at the edge that ends the wait.
    assign wr_done  = avs_write && !st_ff.waitreq;
    assign cmd_wr   = wr_done && (avs_address == omos_pkg::REG_CMD);
    assign cmd_shut = cmd_wr && avs_writedata[omos_pkg::CMD_SHUT_BIT];
    assign cmd_cs   = cmd_wr && avs_writedata[omos_pkg::CMD_CSTART_BIT];
    assign cmd_ce   = cmd_wr && avs_writedata[omos_pkg::CMD_CEND_BIT];

    function automatic logic is_on(input omos_pkg::omos_state_t s);
        is_on = (s == omos_pkg::OMOS_IDLE) || (s == omos_pkg::OMOS_ACTIVE) || (s == omos_pkg::OMOS_CONN);
    endfunction

    always_comb begin
        logic [15:0]                  period;
        logic                         wake;
        logic                         awake;
        logic [omos_pkg::DATA_W-1:0]  rd;
        omos_pkg::omos_state_t        code;
        period = st_ff.cfg.net_reg ? st_ff.cfg.wake_reg : st_ff.cfg.wake_unreg;
        wake   = 1'b0;
        awake  = 1'b0;
        rd     = '0;
        code   = st_ff.state;
        nxt_st = st_ff;

        // Bus: one wait cycle, then the answer with waitrequest low.
        if (st_ff.waitreq && (avs_read || avs_write)) begin
            nxt_st.waitreq = 1'b0;
        end else begin
            nxt_st.waitreq = 1'b1;
        end
        if (is_on(st_ff.state) && chg) begin
            code = omos_pkg::OMOS_CHARGE;
        end
        case (avs_address)
            omos_pkg::REG_CTRL: begin
                rd[omos_pkg::CTRL_PSV_LSB +: 2]   = st_ff.cfg.psv;
                rd[omos_pkg::CTRL_FLOW_BIT]       = st_ff.cfg.flow_en;
                rd[omos_pkg::CTRL_NETREG_BIT]     = st_ff.cfg.net_reg;
            end
            omos_pkg::REG_STATUS: begin
                rd[omos_pkg::ST_MODE_LSB +: 3]    = code;
                rd[omos_pkg::ST_RAW_LSB +: 3]     = st_ff.state;
                rd[omos_pkg::ST_PREV_BIT]         = st_ff.prev_idle;
                rd[omos_pkg::ST_CHG_BIT]          = chg;
                rd[omos_pkg::ST_SUP_BIT]          = sup;
                rd[omos_pkg::ST_NETREG_BIT]       = st_ff.cfg.net_reg;
            end
            omos_pkg::REG_WAKE: begin
                rd[omos_pkg::WAKE_REG_LSB +: 16]  = st_ff.cfg.wake_reg;
                rd[omos_pkg::WAKE_UNREG_LSB +: 16] = st_ff.cfg.wake_unreg;
            end
            default: rd = '0;
        endcase
        if (st_ff.waitreq && avs_read) begin
            nxt_st.rdata = rd;
        end
        if (wr_done && (avs_address == omos_pkg::REG_CTRL)) begin
            nxt_st.cfg.psv     = avs_writedata[omos_pkg::CTRL_PSV_LSB +: 2];
            nxt_st.cfg.flow_en = avs_writedata[omos_pkg::CTRL_FLOW_BIT];
            nxt_st.cfg.net_reg = avs_writedata[omos_pkg::CTRL_NETREG_BIT];
        end
        if (wr_done && (avs_address == omos_pkg::REG_WAKE)) begin
            nxt_st.cfg.wake_reg   = avs_writedata[omos_pkg::WAKE_REG_LSB +: 16];
            nxt_st.cfg.wake_unreg = avs_writedata[omos_pkg::WAKE_UNREG_LSB +: 16];
        end

        // Losing supply overrides every state, as the module switches off at once.
        if (!sup) begin
            nxt_st.state = chg ? omos_pkg::OMOS_PRECHG : omos_pkg::OMOS_NOPWR;
        end else begin
            case (st_ff.state)
                omos_pkg::OMOS_NOPWR, omos_pkg::OMOS_PRECHG: begin
                    // Supply coming back only arms the switch-on sources.
                    nxt_st.state = omos_pkg::OMOS_OFF;
                end
                omos_pkg::OMOS_OFF: begin
                    if (sw_f || al_r || chg_r) begin
                        nxt_st.state    = omos_pkg::OMOS_ACTIVE;
                        nxt_st.hold_cnt = '0;
                    end
                end
                omos_pkg::OMOS_IDLE: begin
                    if (tick) begin
                        if (16'(st_ff.wake_cnt + 16'h1) >= period) begin
                            awake = 1'b1;
                        end else begin
                            nxt_st.wake_cnt = st_ff.wake_cnt + 16'h1;
                        end
                    end
                    wake = awake || al_r
                        || (st_ff.cfg.flow_en && txd_f)
                        || ((st_ff.cfg.psv == omos_pkg::PSV_RTS) && rts_f);
                    if (cmd_shut) begin
                        nxt_st.state = omos_pkg::OMOS_OFF;
                    end else if (cmd_cs) begin
                        nxt_st.state     = omos_pkg::OMOS_CONN;
                        nxt_st.prev_idle = 1'b1;
                    end else if (wake) begin
                        nxt_st.state    = omos_pkg::OMOS_ACTIVE;
                        nxt_st.hold_cnt = '0;
                    end
                end
                omos_pkg::OMOS_ACTIVE: begin
                    if (cmd_shut) begin
                        nxt_st.state = omos_pkg::OMOS_OFF;
                    end else if (cmd_cs) begin
                        nxt_st.state     = omos_pkg::OMOS_CONN;
                        nxt_st.prev_idle = 1'b0;
                    end else if (txd_f || rts_f || al_r || wr_done) begin
                        // Fresh activity restarts the dwell before idle.
                        nxt_st.hold_cnt = '0;
                    end else if (st_ff.cfg.psv != omos_pkg::PSV_OFF) begin
                        if (st_ff.hold_cnt >= omos_pkg::HOLD_W'(HOLD_CYC - 1)) begin
                            nxt_st.state    = omos_pkg::OMOS_IDLE;
                            nxt_st.wake_cnt = '0;
                        end else begin
                            nxt_st.hold_cnt = st_ff.hold_cnt + omos_pkg::HOLD_W'(1);
                        end
                    end
                end
                omos_pkg::OMOS_CONN: begin
                    if (cmd_shut) begin
                        nxt_st.state = omos_pkg::OMOS_OFF;
                    end else if (cmd_ce) begin
                        nxt_st.state    = st_ff.prev_idle ? omos_pkg::OMOS_IDLE : omos_pkg::OMOS_ACTIVE;
                        nxt_st.hold_cnt = '0;
                        nxt_st.wake_cnt = '0;
                    end
                end
                default: nxt_st.state = omos_pkg::OMOS_NOPWR;
            endcase
        end

        // Outputs follow the next state so they change on the same edge.
        nxt_st.pins.ref_fast    = (nxt_st.state == omos_pkg::OMOS_ACTIVE)
                                  || (nxt_st.state == omos_pkg::OMOS_CONN);
        nxt_st.pins.if_en       = nxt_st.pins.ref_fast;
        nxt_st.pins.cts_n       = !nxt_st.pins.ref_fast;
        nxt_st.pins.precharge   = (nxt_st.state == omos_pkg::OMOS_PRECHG);
        nxt_st.pins.charge_ctrl = chg && sup && is_on(nxt_st.state);
        nxt_st.pins.rtc_run     = sup;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff                <= '0;
            st_ff.state          <= omos_pkg::OMOS_NOPWR;
            st_ff.cfg.psv        <= omos_pkg::PSV_RESET;
            st_ff.cfg.flow_en    <= omos_pkg::FLOW_RESET;
            st_ff.cfg.wake_reg   <= omos_pkg::WAKE_REG_RESET;
            st_ff.cfg.wake_unreg <= omos_pkg::WAKE_UNREG_RESET;
            st_ff.pins.cts_n     <= 1'b1;
            st_ff.waitreq        <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata    = st_ff.rdata;
    assign avs_waitrequest = st_ff.waitreq;
    assign mode_pins       = st_ff.pins;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_off_switch_on: assert property (
        (st_ff.state == omos_pkg::OMOS_OFF) && sup && sw_f |=> (st_ff.state == omos_pkg::OMOS_ACTIVE))
        else $error("switch-on edge did not leave power-off");
    a_off_alarm_chg: assert property (
        (st_ff.state == omos_pkg::OMOS_OFF) && sup && (al_r || chg_r) |=> st_ff.pins.if_en)
        else $error("alarm or charger edge did not switch on");
    a_nopwr_ignore: assert property (
        !sup |=> !st_ff.pins.if_en ##1 !st_ff.pins.if_en)
        else $error("device switched on without supply");
    a_shutdown_off: assert property (
        is_on(st_ff.state) && sup && cmd_shut |=> (st_ff.state == omos_pkg::OMOS_OFF) && !st_ff.pins.if_en)
        else $error("shutdown command did not reach power-off");
    a_idle_disabled: assert property (
        (st_ff.cfg.psv == omos_pkg::PSV_OFF) && (st_ff.state == omos_pkg::OMOS_ACTIVE) && sup
        && !cmd_cs && !cmd_shut |=> (st_ff.state == omos_pkg::OMOS_ACTIVE))
        else $error("idle entered while power saving is off");
    a_idle_rtc_wake: assert property (
        (st_ff.state == omos_pkg::OMOS_IDLE) && sup && al_r && !cmd_shut && !cmd_cs
        |=> (st_ff.state == omos_pkg::OMOS_ACTIVE))
        else $error("alarm did not wake idle");
    a_rts_wake: assert property (
        (st_ff.state == omos_pkg::OMOS_IDLE) && sup && rts_f && !al_r && !txd_f && !tick && !wr_done
        |=> (st_ff.state == ((st_ff.cfg.psv == omos_pkg::PSV_RTS) ? omos_pkg::OMOS_ACTIVE : omos_pkg::OMOS_IDLE)))
        else $error("request-to-send wake does not follow the setting");
    a_cts_idle_off: assert property (
        (st_ff.state == omos_pkg::OMOS_IDLE) |-> st_ff.pins.cts_n && !st_ff.pins.if_en)
        else $error("clear-to-send on while idle");
    a_ref_clock_sel: assert property (
        st_ff.pins.ref_fast == ((st_ff.state == omos_pkg::OMOS_ACTIVE) || (st_ff.state == omos_pkg::OMOS_CONN)))
        else $error("reference select disagrees with state");
    a_conn_return: assert property (
        (st_ff.state == omos_pkg::OMOS_CONN) && sup && cmd_ce && !cmd_shut
        |=> (st_ff.state == ($past(st_ff.prev_idle) ? omos_pkg::OMOS_IDLE : omos_pkg::OMOS_ACTIVE)))
        else $error("call end went to the wrong state");
    a_precharge_force: assert property (
        !sup && chg |=> st_ff.pins.precharge && !st_ff.pins.if_en)
        else $error("pre-charge not forced");
    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after the request");

    c_switch_on:  cover property ((st_ff.state == omos_pkg::OMOS_OFF) ##1 (st_ff.state == omos_pkg::OMOS_ACTIVE));
    c_idle_wake:  cover property ((st_ff.state == omos_pkg::OMOS_IDLE) ##1 (st_ff.state == omos_pkg::OMOS_ACTIVE));
    c_call_round: cover property ((st_ff.state == omos_pkg::OMOS_CONN) ##1 (st_ff.state == omos_pkg::OMOS_IDLE));
    c_precharge:  cover property (st_ff.pins.precharge);

endmodule // omos_sequencer

`default_nettype wire

// ===== verification/omos_host_model.sv
`default_nettype none

module omos_host_model (
    // Clock.
    input  wire logic clk,
    // Requests from the bench.
    input  wire logic dev_up,
    input  wire logic press,
    input  wire logic send,
    input  wire logic rts_on,
    // Lines into the device.
    output logic      switch_on_input_n,
    output logic      rts_n,
    output logic      host_txd
);
    timeunit 1ns;
    timeprecision 1ps;
    // The board pull-up keeps the switch input high between presses.
    assign switch_on_input_n = !press;
    // Lines stay low while the device is down, so it is never back-powered.
    always @(posedge clk) begin
        rts_n <= dev_up ? !rts_on : 1'b0;
        host_txd <= dev_up ? !send : 1'b0;
    end
endmodule // omos_host_model

`default_nettype wire

// ===== verification/omos_sequencer_tb.sv
`default_nettype none

module omos_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, resetn, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, w;
    logic        supply_ok, charger_detect, rtc_alarm, dev_up, press, send, rts_on;
    logic        switch_on_input_n, rts_n, host_txd;
    omos_pkg::omos_pins_t mode_pins;
    int          n_mismatch = 0;
    int          n_checks = 0;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // The dwell must outlast a few status polls, or a short active spell slips between two reads.
    omos_sequencer #(.TICK_DIV(4), .HOLD_CYC(40)) DUT (
        .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .supply_ok(supply_ok), .charger_detect(charger_detect),
        .switch_on_input_n(switch_on_input_n), .rtc_alarm(rtc_alarm), .rts_n(rts_n),
        .host_txd(host_txd), .mode_pins(mode_pins));

    omos_host_model host (.clk(clk), .dev_up(dev_up), .press(press), .send(send), .rts_on(rts_on),
        .switch_on_input_n(switch_on_input_n), .rts_n(rts_n), .host_txd(host_txd));

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_pin(input logic [5:0] m, input logic [5:0] e);
        chk_reg("mode_pins", {26'h0, e}, {26'h0, mode_pins & m});
    endtask

    // An edge passes first, so a new request never lands on the release of the last one.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wait_mode(input logic [2:0] e, input int tries);
        for (int i = 0; i < tries; i++) begin
            bus(1'b0, omos_pkg::REG_STATUS, 32'h0);
            if (rd[2:0] === e) break;
        end
        chk_reg("mode", {29'h0, e}, {29'h0, rd[2:0]});
    endtask

    task automatic pulse_alarm;
        rtc_alarm <= 1'b1;
        repeat (5) @(posedge clk);
        rtc_alarm <= 1'b0;
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h8D89));
        {resetn, avs_read, avs_write, supply_ok, charger_detect, rtc_alarm} = 6'h0;
        {dev_up, press, send, rts_on} = 4'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        press <= 1'b1;
        pulse_alarm();
        press <= 1'b0;
        wait_mode(omos_pkg::OMOS_NOPWR, 1);
        supply_ok <= 1'b1;
        wait_mode(omos_pkg::OMOS_OFF, 40);
        bus(1'b0, omos_pkg::REG_CTRL, 32'h0);
        chk_reg("ctrl", 32'h5, rd);
        bus(1'b0, omos_pkg::REG_WAKE, 32'h0);
        chk_reg("wake", 32'h40000800, rd);
        bus(1'b1, 4'h2, 32'hFFFFFFFF);
        bus(1'b0, 4'h2, 32'h0);
        chk_reg("unmapped", 32'h0, rd);
        $display("test reset done");
        press <= 1'b1;
        repeat ($urandom_range(4, 9)) @(posedge clk);
        press <= 1'b0;
        wait_mode(omos_pkg::OMOS_ACTIVE, 40);
        dev_up <= 1'b1;
        chk_pin(6'h38, 6'h18);
        wait_mode(omos_pkg::OMOS_IDLE, 40);
        chk_pin(6'h38, 6'h20);
        w = $urandom | 32'h80008000;
        bus(1'b1, omos_pkg::REG_WAKE, w);
        bus(1'b0, omos_pkg::REG_WAKE, 32'h0);
        chk_reg("wake", w, rd);
        for (int k = 0; k < 2; k++) begin
            if (k == 0)
                pulse_alarm();
            else
                send <= 1'b1;
            repeat ($urandom_range(2, 6)) @(posedge clk);
            send <= 1'b0;
            wait_mode(omos_pkg::OMOS_ACTIVE, 40);
            wait_mode(omos_pkg::OMOS_IDLE, 40);
        end
        rts_on <= 1'b1;
        repeat (12) @(posedge clk);
        wait_mode(omos_pkg::OMOS_IDLE, 1);
        rts_on <= 1'b0;
        bus(1'b1, omos_pkg::REG_CTRL, 32'h6);
        rts_on <= 1'b1;
        wait_mode(omos_pkg::OMOS_ACTIVE, 40);
        rts_on <= 1'b0;
        bus(1'b1, omos_pkg::REG_CTRL, 32'h4);
        repeat (60) @(posedge clk);
        wait_mode(omos_pkg::OMOS_ACTIVE, 1);
        bus(1'b1, omos_pkg::REG_CTRL, 32'h5);
        wait_mode(omos_pkg::OMOS_IDLE, 40);
        $display("test wake done");
        bus(1'b1, omos_pkg::REG_CMD, 32'h2);
        wait_mode(omos_pkg::OMOS_CONN, 40);
        chk_pin(6'h38, 6'h18);
        bus(1'b1, omos_pkg::REG_CMD, 32'h4);
        wait_mode(omos_pkg::OMOS_IDLE, 1);
        pulse_alarm();
        bus(1'b1, omos_pkg::REG_CMD, 32'h2);
        wait_mode(omos_pkg::OMOS_CONN, 40);
        bus(1'b1, omos_pkg::REG_CMD, 32'h4);
        wait_mode(omos_pkg::OMOS_ACTIVE, 1);
        bus(1'b1, omos_pkg::REG_WAKE, 32'h00020003);
        wait_mode(omos_pkg::OMOS_IDLE, 40);
        wait_mode(omos_pkg::OMOS_ACTIVE, 40);
        bus(1'b1, omos_pkg::REG_CTRL, 32'hD);
        wait_mode(omos_pkg::OMOS_IDLE, 40);
        wait_mode(omos_pkg::OMOS_ACTIVE, 40);
        bus(1'b1, omos_pkg::REG_WAKE, 32'hFFFFFFFF);
        $display("test call and timer done");
        bus(1'b1, omos_pkg::REG_CMD, 32'h1);
        wait_mode(omos_pkg::OMOS_OFF, 40);
        dev_up <= 1'b0;
        chk_pin(6'h09, 6'h01);
        pulse_alarm();
        wait_mode(omos_pkg::OMOS_ACTIVE, 40);
        bus(1'b1, omos_pkg::REG_CMD, 32'h1);
        wait_mode(omos_pkg::OMOS_OFF, 40);
        charger_detect <= 1'b1;
        wait_mode(3'h6, 40);
        chk_pin(6'h02, 6'h02);
        supply_ok <= 1'b0;
        wait_mode(omos_pkg::OMOS_PRECHG, 40);
        chk_pin(6'h0C, 6'h04);
        press <= 1'b1;
        repeat (8) @(posedge clk);
        press <= 1'b0;
        wait_mode(omos_pkg::OMOS_PRECHG, 1);
        $display("test power done");
        report_and_stop();
    end
endmodule // omos_sequencer_tb

`default_nettype wire
